// File: rtl/dsc_dev.sv
// configuration port end: instruction decode, data phase, write delivery
// assumes the register file answers rd_data_i combinationally from rd_addr_o
`include "dsc_cfg.svh"

// Contract
// [R1] instruction byte on first eight rising edges
// [R2] decode direction, byte count, start address
// [R3] reset pin pulse restores register defaults
// [R4] reset pin returns sequencer to instruction
// [R5] reset mid-transfer commits no partial byte
// [R6] data phase moves exactly selected byte count
// [R7] write commits at each byte's last bit
// [R8] single bidirectional data pin for both directions
// [R9] read and write, single or multibyte
// [R10] master pulses reset after supplies applied
// [R11] bit7 read flag, bits6-5 count, bits4-0 address
// [R12] count field 00..11 means one..four bytes
// [R13] sample rising, drive falling, max 25 MHz
// [R14] chip select low whole cycle; high releases pin
// [R15] drive pin only in read data phase
module dsc_dev (
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // system reset, active low
	dsc_if.dev link, // serial link, device side
	output dsc_pkg::dsc_addr_t rd_addr_o, // read address, link domain
	input wire dsc_pkg::dsc_byte_t rd_data_i, // read data for rd_addr_o
	output logic wr_valid_o, // one-cycle write strobe, mclk
	output dsc_pkg::dsc_addr_t wr_addr_o, // write address, mclk
	output dsc_pkg::dsc_byte_t wr_data_o, // write data, mclk
	output logic defaults_o, // one-cycle load-defaults pulse, mclk
	output logic strapped_pin_operation_o // reset pin seen high, mclk
);
	import dsc_pkg::*;

	// ==========================================================
	// link-domain sequencer
	// [R4] asynchronous return to instruction
	// chip select high also aborts, so a stray edge never resumes a stale cycle
	logic link_arst;
	assign link_arst = link.cs_n | link.hw_reset_strap_pin;

	dsc_dev_st_e st_q, st_d;
	logic [2:0] bit_q, bit_d;
	logic [6:0] sh_q, sh_d;
	logic rw_q, rw_d;
	logic [1:0] left_q, left_d;
	dsc_addr_t addr_q, addr_d;
	dsc_addr_t cm_addr_q, cm_addr_d;
	dsc_byte_t cm_data_q, cm_data_d;
	logic tog_q, tog_d;
	dsc_byte_t byte_w;

	assign byte_w = {sh_q, link.sdio};

	always_comb begin
		st_d = st_q;
		bit_d = bit_q + 3'h1;
		sh_d = {sh_q[5:0], link.sdio};
		rw_d = rw_q;
		left_d = left_q;
		addr_d = addr_q;
		cm_addr_d = cm_addr_q;
		cm_data_d = cm_data_q;
		tog_d = tog_q;
		unique case (st_q)
			DSC_DEV_INSTR: begin
				// [R1] eighth rising edge ends instruction
				if (bit_q == 3'h7) begin
					// [R2] instruction field decode
					// [R11] field positions
					rw_d = byte_w[`DSC_INS_RW_BIT];
					left_d = byte_w[`DSC_INS_CNT_HI:`DSC_INS_CNT_LO];
					addr_d = byte_w[`DSC_INS_ADR_HI:`DSC_INS_ADR_LO];
					st_d = DSC_DEV_DATA;
				end
			end
			DSC_DEV_DATA: begin
				if (bit_q == 3'h7) begin
					// [R7] commit each write byte on its last bit
					if (!rw_q) begin
						cm_addr_d = addr_q;
						cm_data_d = byte_w;
						tog_d = ~tog_q;
					end
					// [R6] [R12] stop after count field plus one bytes
					if (left_q == 2'h0) begin
						st_d = DSC_DEV_DONE;
					end else begin
						left_d = left_q - 2'h1;
						// msb-first order: address steps downward
						addr_d = addr_q - 5'h01;
					end
				end
			end
			DSC_DEV_DONE: begin
				// surplus clocks are ignored until chip select rises
				bit_d = bit_q;
			end
		endcase
	end

	// [R13] incoming bits taken on rising edge
	always_ff @(posedge link.sclk or posedge link_arst) begin
		if (link_arst) begin
			st_q <= DSC_DEV_INSTR;
			bit_q <= 3'h0;
			sh_q <= 7'h00;
			rw_q <= 1'b0;
			left_q <= 2'h0;
			addr_q <= 5'h00;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			left_q <= left_d;
			addr_q <= addr_d;
		end
	end

	// [R5] only whole bytes reach the commit stage
	// survives chip select so a finished byte is still delivered
	always_ff @(posedge link.sclk or posedge link.hw_reset_strap_pin) begin
		if (link.hw_reset_strap_pin) begin
			cm_addr_q <= 5'h00;
			cm_data_q <= 8'h00;
			tog_q <= 1'b0;
		end else begin
			cm_addr_q <= cm_addr_d;
			cm_data_q <= cm_data_d;
			tog_q <= tog_d;
		end
	end

	assign rd_addr_o = addr_q;

	// ==========================================================
	// read driver on falling edge
	logic rd_phase;
	logic oe_q, oe_d;
	dsc_byte_t tx_q, tx_d;
	assign rd_phase = (st_q == DSC_DEV_DATA) && rw_q;

	always_comb begin
		oe_d = 1'b0;
		tx_d = tx_q;
		// [R15] drive only while a read byte is due
		// [R9] read path, one to four bytes
		if (rd_phase) begin
			oe_d = 1'b1;
			tx_d = (bit_q == 3'h0) ? rd_data_i : {tx_q[6:0], 1'b0};
		end
	end

	// [R13] outgoing bits change on falling edge
	// [R14] chip select high releases the pin at once
	always_ff @(negedge link.sclk or posedge link_arst) begin
		if (link_arst) begin
			oe_q <= 1'b0;
			tx_q <= 8'h00;
		end else begin
			oe_q <= oe_d;
			tx_q <= tx_d;
		end
	end

	// [R8] one shared data line
	assign link.dev_sdio_o = tx_q[7];
	assign link.dev_sdio_oe = oe_q;

	// ==========================================================
	// system-domain delivery
	logic [1:0] tsync_q, tsync_d;
	logic tlast_q, tlast_d;
	logic [1:0] ssync_q, ssync_d;
	logic slast_q, slast_d;
	logic wv_q, wv_d;
	logic def_q, def_d;
	logic armed_q, armed_d;
	logic wr_hit;
	dsc_addr_t wa_q, wa_d;
	dsc_byte_t wd_q, wd_d;

	// the commit toggle is cleared only by the pin, so writes before the first pulse are dropped
	// a toggle flip caused by the pin itself lands while the pin is seen high and is absorbed
	assign wr_hit = armed_q & (tsync_q[1] ^ tlast_q) & ~(ssync_q[1] | slast_q);

	always_comb begin
		tsync_d = {tsync_q[0], tog_q};
		tlast_d = tsync_q[1];
		ssync_d = {ssync_q[0], link.hw_reset_strap_pin};
		slast_d = ssync_q[1];
		wv_d = wr_hit;
		wa_d = wa_q;
		wd_d = wd_q;
		// commit data is held for a whole byte time, far longer than the sync delay
		if (wr_hit) begin
			wa_d = cm_addr_q;
			wd_d = cm_data_q;
		end
		// [R3] defaults loaded when reset pin falls
		def_d = slast_q & ~ssync_q[1];
		armed_d = armed_q | def_d;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tsync_q <= 2'h0;
			tlast_q <= 1'b0;
			ssync_q <= 2'h0;
			slast_q <= 1'b0;
			wv_q <= 1'b0;
			def_q <= 1'b0;
			armed_q <= 1'b0;
			wa_q <= 5'h00;
			wd_q <= 8'h00;
		end else begin
			tsync_q <= tsync_d;
			tlast_q <= tlast_d;
			ssync_q <= ssync_d;
			slast_q <= slast_d;
			wv_q <= wv_d;
			def_q <= def_d;
			armed_q <= armed_d;
			wa_q <= wa_d;
			wd_q <= wd_d;
		end
	end

	assign wr_valid_o = wv_q;
	assign wr_addr_o = wa_q;
	assign wr_data_o = wd_q;
	assign defaults_o = def_q;
	// pin left high means the strap mode is in use instead of the port
	assign strapped_pin_operation_o = slast_q;
endmodule : dsc_dev

// File: rtl/dsc_cfg.svh
// constants shared by both ends of the serial configuration port
// assumes a 200 MHz system clock; the link clock comes from the host divider
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// ==========================================================
// instruction byte fields
`define DSC_INS_RW_BIT 7
`define DSC_INS_CNT_HI 6
`define DSC_INS_CNT_LO 5
`define DSC_INS_ADR_HI 4
`define DSC_INS_ADR_LO 0
`define DSC_BITS_PER_BYTE 8

// ==========================================================
// timing
`define DSC_MCLK_NS 5
`define DSC_RST_MIN_NS 50
`define DSC_RST_CYCLES ((`DSC_RST_MIN_NS + `DSC_MCLK_NS - 1) / `DSC_MCLK_NS)
`define DSC_SCLK_MAX_MHZ 25
// half link period in system cycles: 200 MHz / (2 * 4) = 25 MHz
`define DSC_SCLK_HALF_CYC 4

`endif

// File: rtl/dsc_pkg.sv
// types shared by both ends of the serial configuration port
// assumes dsc_cfg.svh provides the numeric constants
package dsc_pkg;
	typedef enum logic [1:0] {
		DSC_DEV_INSTR = 2'b00,
		DSC_DEV_DATA = 2'b01,
		DSC_DEV_DONE = 2'b10
	} dsc_dev_st_e;
	typedef enum logic [2:0] {
		DSC_HST_IDLE = 3'b000,
		DSC_HST_RST = 3'b001,
		DSC_HST_LOW = 3'b010,
		DSC_HST_HIGH = 3'b011,
		DSC_HST_FIN = 3'b100
	} dsc_hst_st_e;
	typedef logic [4:0] dsc_addr_t;
	typedef logic [7:0] dsc_byte_t;
endpackage : dsc_pkg

// File: rtl/dsc_if.sv
// link between serial master and configuration port
// the shared data line is resolved here from the two drive enables; idle level is high
interface dsc_if;
	logic sclk;
	logic cs_n;
	logic hw_reset_strap_pin;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic sdio;
	// ==========================================================
	// wire resolution, pull-up when nobody drives
	assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
	modport host (
		output sclk, cs_n, hw_reset_strap_pin, host_sdio_o, host_sdio_oe,
		input sdio
	);
	modport dev (
		input sclk, cs_n, hw_reset_strap_pin, sdio,
		output dev_sdio_o, dev_sdio_oe
	);
endinterface : dsc_if

// File: rtl/dsc_host.sv
// serial master end: reset pulse, link clock divider, framing of one cycle
// assumes the user holds the request fields stable while start_i is high
`include "dsc_cfg.svh"

module dsc_host #(
	parameter int HALF_CYC = `DSC_SCLK_HALF_CYC, // system cycles per half link period
	parameter int RST_CYC = `DSC_RST_CYCLES // reset pin high time in system cycles
) (
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // system reset, active low
	dsc_if.host link, // serial link, master side
	input wire logic start_i, // start a cycle, taken when idle
	input wire logic rw_i, // 1 read, 0 write
	input wire logic [1:0] cnt_i, // byte count code, 0 means one byte
	input wire dsc_pkg::dsc_addr_t addr_i, // start register address
	input wire logic [31:0] wdata_i, // write bytes, first byte in [31:24]
	input wire logic reset_req_i, // request a reset pulse, taken when idle
	output logic busy_o, // cycle or reset in progress
	output logic done_o, // one-cycle end pulse
	output logic [31:0] rdata_o // read bytes, last byte in [7:0]
);
	import dsc_pkg::*;

	dsc_hst_st_e st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	logic [5:0] idx_q, idx_d;
	logic [5:0] last_q, last_d;
	logic [39:0] sh_q, sh_d;
	logic [31:0] rx_q, rx_d;
	logic rw_q, rw_d;
	logic sclk_q, sclk_d;
	logic cs_n_q, cs_n_d;
	logic strap_q, strap_d;
	logic oe_q, oe_d;
	logic done_q, done_d;
	logic [1:0] din_q;
	logic tick;

	assign tick = (cnt_q == 8'(HALF_CYC - 1));

	// ==========================================================
	// data line input synchroniser
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			din_q <= 2'h3;
		end else begin
			din_q <= {din_q[0], link.sdio};
		end
	end

	always_comb begin
		st_d = st_q;
		cnt_d = tick ? 8'h00 : cnt_q + 8'h01;
		idx_d = idx_q;
		last_d = last_q;
		sh_d = sh_q;
		rx_d = rx_q;
		rw_d = rw_q;
		sclk_d = sclk_q;
		cs_n_d = cs_n_q;
		strap_d = strap_q;
		oe_d = oe_q;
		done_d = 1'b0;
		unique case (st_q)
			DSC_HST_IDLE: begin
				cnt_d = 8'h00;
				if (reset_req_i) begin
					strap_d = 1'b1;
					st_d = DSC_HST_RST;
				end else if (start_i) begin
					sh_d = {rw_i, cnt_i, addr_i, wdata_i};
					rw_d = rw_i;
					last_d = 6'({cnt_i, 3'h7}) + 6'h08;
					idx_d = 6'h00;
					rx_d = 32'h0000_0000;
					cs_n_d = 1'b0;
					oe_d = 1'b1;
					st_d = DSC_HST_LOW;
				end
			end
			DSC_HST_RST: begin
				cnt_d = cnt_q + 8'h01;
				// [R3] [R10] reset pin high for at least the minimum time
				if (cnt_q == 8'(RST_CYC - 1)) begin
					strap_d = 1'b0;
					done_d = 1'b1;
					st_d = DSC_HST_IDLE;
				end
			end
			DSC_HST_LOW: begin
				if (tick) begin
					sclk_d = 1'b1;
					// [R13] read bits taken at the rising edge
					if (rw_q && idx_q > 6'h07) begin
						rx_d = {rx_q[30:0], din_q[1]};
					end
					st_d = DSC_HST_HIGH;
				end
			end
			DSC_HST_HIGH: begin
				if (tick) begin
					sclk_d = 1'b0;
					if (idx_q == last_q) begin
						oe_d = 1'b0;
						st_d = DSC_HST_FIN;
					end else begin
						idx_d = idx_q + 6'h01;
						sh_d = {sh_q[38:0], 1'b0};
						// [R8] release the line for read data
						oe_d = !rw_q || idx_q < 6'h07;
						st_d = DSC_HST_LOW;
					end
				end
			end
			DSC_HST_FIN: begin
				// [R14] chip select held low through the last bit
				if (tick) begin
					cs_n_d = 1'b1;
					done_d = 1'b1;
					st_d = DSC_HST_IDLE;
				end
			end
			default: begin
				st_d = DSC_HST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= DSC_HST_IDLE;
			cnt_q <= 8'h00;
			idx_q <= 6'h00;
			last_q <= 6'h00;
			sh_q <= 40'h00_0000_0000;
			rx_q <= 32'h0000_0000;
			rw_q <= 1'b0;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			strap_q <= 1'b0;
			oe_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			last_q <= last_d;
			sh_q <= sh_d;
			rx_q <= rx_d;
			rw_q <= rw_d;
			sclk_q <= sclk_d;
			cs_n_q <= cs_n_d;
			strap_q <= strap_d;
			oe_q <= oe_d;
			done_q <= done_d;
		end
	end

	// [R1] instruction first, msb first
	assign link.sclk = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.hw_reset_strap_pin = strap_q;
	assign link.host_sdio_o = sh_q[39];
	assign link.host_sdio_oe = oe_q;
	assign busy_o = (st_q != DSC_HST_IDLE);
	assign done_o = done_q;
	assign rdata_o = rx_q;
endmodule : dsc_host

// File: dv/dsc_checker.sv
// link checker: watches the serial link joining master and configuration port
// assumes the link clock comes from mclk_i with four system cycles per half period
module dsc_checker (
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // reset, active low
	input wire logic sclk, // link clock
	input wire logic cs_n, // chip select, active low
	input wire logic hw_reset_strap_pin, // reset pin
	input wire logic host_sdio_o, // master data
	input wire logic host_sdio_oe, // master enable
	input wire logic dev_sdio_o, // device data
	input wire logic dev_sdio_oe, // device enable
	input wire logic sdio // resolved line
);
	// ====
	// frame tracking
	logic sclk_q, sclk_d;
	logic [5:0] nr_q, nr_d;
	logic [7:0] ins_q, ins_d;
	always_comb begin
		sclk_d = sclk;
		nr_d = nr_q;
		ins_d = ins_q;
		if (cs_n || hw_reset_strap_pin) begin
			nr_d = 6'h00;
		end else if (sclk && !sclk_q) begin
			nr_d = nr_q + 6'h01;
			if (nr_q < 6'h08) begin
				ins_d = {ins_q[6:0], sdio};
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b0;
			nr_q <= 6'h00;
			ins_q <= 8'h00;
		end else begin
			sclk_q <= sclk_d;
			nr_q <= nr_d;
			ins_q <= ins_d;
		end
	end
	// ====
	// properties
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_cs_release: assert property (cs_n && $past(cs_n) |-> !dev_sdio_oe)
		else $error("data driven while deselected");
	chk_strap_idle: assert property (hw_reset_strap_pin && $past(hw_reset_strap_pin)
		|-> !dev_sdio_oe) else $error("data driven in reset");
	chk_read_drive: assert property (dev_sdio_oe |-> ins_q[7] && nr_q >= 6'h08)
		else $error("device drives outside read data");
	chk_no_contend: assert property (dev_sdio_oe |-> !host_sdio_oe)
		else $error("both ends drive the line");
	chk_drive_fall: assert property (dev_sdio_oe && $past(dev_sdio_oe)
		&& $changed(dev_sdio_o) |-> $fell(sclk)) else $error("read bit not on falling edge");
	chk_host_setup: assert property (sclk && host_sdio_oe |-> $stable(host_sdio_o))
		else $error("master data moves while clock high");
	chk_sclk_half: assert property ($changed(sclk) |=> $stable(sclk)[*3])
		else $error("link clock too fast");
	chk_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("link clock outside frame");
	chk_frame_len: assert property ($rose(cs_n) |-> nr_q == {3'(ins_q[6:5]) + 3'h2, 3'h0})
		else $error("frame length differs from count");
	chk_rst_width: assert property ($rose(hw_reset_strap_pin) |-> hw_reset_strap_pin[*8]
		##1 hw_reset_strap_pin ##1 hw_reset_strap_pin) else $error("reset pulse short");
	cover property ($rose(dev_sdio_oe));
	cover property ($rose(cs_n) && nr_q == 6'h28);
	cover property ($fell(hw_reset_strap_pin));
endmodule : dsc_checker

// File: dv/tb_dac_serial_config_port.sv
// bench: master and port joined by the link, plus a bench-driven link for aborts
// assumes the rtl files are compiled first
module tb_dac_serial_config_port;
	timeunit 1ns;
	timeprecision 100ps;
	import dsc_pkg::*;
	logic mclk_i, start_i = 0, rw_i = 0, reset_req_i = 0, done, wv, dflt, seen, rd_pend = 0;
	logic rst_n_i = 0, w2v, d2, busy;
	logic [1:0] cnt_i = 0;
	logic [31:0] wdata_i = 0, rdata;
	dsc_addr_t addr_i = 0, rd_addr, wr_addr, w2a;
	dsc_byte_t rd_data, wr_data, w2d;
	dsc_byte_t rf [32] = '{default: 8'h00};
	dsc_byte_t mdl [32] = '{default: 8'h00};
	logic [38:0] notes [$];
	logic [12:0] got2 = 0;
	int n_fail = 0, tests_run = 0, cyc = 0, seed = 89, n_w2 = 0, n_d2 = 0;
	dsc_if i_dsc_if ();
	dsc_if i_dsc_if_ab ();
	dsc_host i_dsc_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(i_dsc_if),
		.start_i(start_i), .rw_i(rw_i), .cnt_i(cnt_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.reset_req_i(reset_req_i), .busy_o(busy), .done_o(done), .rdata_o(rdata));
	dsc_dev i_dsc_dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(i_dsc_if),
		.rd_addr_o(rd_addr), .rd_data_i(rd_data), .wr_valid_o(wv), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .defaults_o(dflt), .strapped_pin_operation_o(seen));
	dsc_dev i_dsc_dev_ab (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(i_dsc_if_ab),
		.rd_addr_o(), .rd_data_i(8'h00), .wr_valid_o(w2v), .wr_addr_o(w2a),
		.wr_data_o(w2d), .defaults_o(d2), .strapped_pin_operation_o());
	dsc_checker i_dsc_checker (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk(i_dsc_if.sclk),
		.cs_n(i_dsc_if.cs_n), .hw_reset_strap_pin(i_dsc_if.hw_reset_strap_pin),
		.host_sdio_o(i_dsc_if.host_sdio_o), .host_sdio_oe(i_dsc_if.host_sdio_oe),
		.dev_sdio_o(i_dsc_if.dev_sdio_o), .dev_sdio_oe(i_dsc_if.dev_sdio_oe),
		.sdio(i_dsc_if.sdio));
	// register file stand-in, answered combinationally
	assign rd_data = rf[rd_addr];
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// ====
	// checking
	task automatic close_out();
		$display("compares %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic check(input logic [38:0] got, input logic [38:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic take(input logic [38:0] got);
		if (notes.size() == 0) check(got, 39'h7FFFFFFFFF);
		else check(got, notes.pop_front());
	endtask : take
	always @(negedge mclk_i) begin
		if (rst_n_i && wv !== 1'b0) begin
			rf[wr_addr] <= wr_data;
			take({2'h1, wr_addr, 24'h0, wr_data});
		end
		if (rst_n_i && dflt !== 1'b0) begin
			rf <= '{default: 8'h00};
			take({2'h2, 37'h0});
		end
		if (rst_n_i && done !== 1'b0 && rd_pend) take({2'h3, 5'h00, rdata});
		if (rst_n_i && done !== 1'b0) check(39'(busy), 39'h0);
		if (w2v) n_w2++;
		if (w2v) got2 = {w2a, w2d};
		if (d2) n_d2++;
	end
	// hang guard, well above the longest expected run
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end
	// ====
	// drivers
	task automatic wait_done();
		do @(negedge mclk_i); while (done !== 1'b1);
	endtask : wait_done
	task automatic do_op(input logic rw, input logic [1:0] c, input dsc_addr_t a,
		input logic [31:0] wd);
		logic [31:0] e;
		e = 32'h0;
		for (int k = 0; k <= c; k++) begin
			if (rw) e = {e[23:0], mdl[a - 5'(k)]};
			else mdl[a - 5'(k)] = wd[31 - 8 * k -: 8];
			if (!rw) notes.push_back({2'h1, a - 5'(k), 24'h0, wd[31 - 8 * k -: 8]});
		end
		if (rw) notes.push_back({2'h3, 5'h00, e});
		@(posedge mclk_i);
		rd_pend <= rw;
		start_i <= 1'b1;
		rw_i <= rw;
		cnt_i <= c;
		addr_i <= a;
		wdata_i <= wd;
		@(posedge mclk_i);
		start_i <= 1'b0;
		@(negedge mclk_i);
		check(39'(busy), 39'h1);
		wait_done();
	endtask : do_op
	task automatic do_reset();
		mdl = '{default: 8'h00};
		notes.push_back({2'h2, 37'h0});
		@(posedge mclk_i);
		rd_pend <= 1'b0;
		reset_req_i <= 1'b1;
		@(posedge mclk_i);
		reset_req_i <= 1'b0;
		repeat (6) @(negedge mclk_i);
		check(39'(seen), 39'h1);
		wait_done();
	endtask : do_reset
	// bench-made link clock, 12 ns period, no phase tie to mclk_i
	task automatic bang(input logic [7:0] b, input int n);
		for (int k = 7; k > 7 - n; k--) begin
			i_dsc_if_ab.host_sdio_o = b[k];
			#6 i_dsc_if_ab.sclk = 1'b1;
			#6 i_dsc_if_ab.sclk = 1'b0;
		end
	endtask : bang
	task automatic pulse();
		#6 i_dsc_if_ab.hw_reset_strap_pin = 1'b1;
		#60 i_dsc_if_ab.hw_reset_strap_pin = 1'b0;
		#30;
	endtask : pulse
	initial begin
		logic [1:0] c;
		dsc_addr_t a;
		i_dsc_if_ab.sclk = 1'b0;
		i_dsc_if_ab.cs_n = 1'b1;
		i_dsc_if_ab.hw_reset_strap_pin = 1'b0;
		i_dsc_if_ab.host_sdio_o = 1'b0;
		i_dsc_if_ab.host_sdio_oe = 1'b0;
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		do_reset();
		for (int j = 0; j < 8; j++) begin
			c = 2'(j);
			a = 5'(c) + 5'($unsigned($random(seed)) % (32 - c));
			do_op(1'b0, c, a, $random(seed));
			do_op(1'b1, c, a, 32'h0);
		end
		do_reset();
		do_op(1'b1, 2'h3, 5'h1F, 32'h0);
		// first pulse brings the second port out of its power-up state
		pulse();
		// aborts in data phase then in instruction phase, then one clean write
		i_dsc_if_ab.cs_n = 1'b0;
		i_dsc_if_ab.host_sdio_oe = 1'b1;
		bang(8'h05, 8);
		bang(8'hA5, 5);
		pulse();
		bang(8'h05, 3);
		pulse();
		bang(8'h05, 8);
		bang(8'h3C, 8);
		#6 i_dsc_if_ab.cs_n = 1'b1;
		i_dsc_if_ab.host_sdio_oe = 1'b0;
		#100;
		check(39'(n_w2), 39'h1);
		check(39'(got2), {26'h0, 5'h05, 8'h3C});
		check(39'(n_d2), 39'h3);
		check(39'(notes.size()), 39'h0);
		close_out();
	end
endmodule : tb_dac_serial_config_port
